/* File: imu_regs.svh */
// register offsets, field positions, reset values and timing counts of the imu serial link
`ifndef IMU_REGS_SVH
`define IMU_REGS_SVH

`define IMU_CLK_HZ            100000000
`define IMU_CLK_PERIOD_NS     10
`define IMU_SAMPLE_SPS        2000
`define IMU_SAMPLE_PERIOD_CYC (`IMU_CLK_HZ / `IMU_SAMPLE_SPS)
`define IMU_DR_PULSE_NS       2000
`define IMU_DR_PULSE_CYC      8'((`IMU_DR_PULSE_NS + `IMU_CLK_PERIOD_NS - 1) / `IMU_CLK_PERIOD_NS)
`define IMU_SCLK_MAX_HZ       1000000
`define IMU_SCLK_HALF_CYC     ((`IMU_CLK_HZ + 2 * `IMU_SCLK_MAX_HZ - 1) / (2 * `IMU_SCLK_MAX_HZ))

`define IMU_CMD_BURST         16'h6800
`define IMU_BURST_WORDS       4'hA
`define IMU_PIN_IDLE          3'h6
`define IMU_HOST_PIN_IDLE     2'h3

// word indices: byte address divided by two
`define IMU_ERR_IDX           6'h01
`define IMU_RATE_X_IDX        6'h03
`define IMU_RATE_Y_IDX        6'h05
`define IMU_RATE_Z_IDX        6'h07
`define IMU_ACCEL_X_IDX       6'h09
`define IMU_ACCEL_Y_IDX       6'h0B
`define IMU_ACCEL_Z_IDX       6'h0D
`define IMU_TEMP_IDX          6'h0E
`define IMU_STAMP_IDX         6'h0F
`define IMU_COUNTER_IDX       6'h11
`define IMU_FILT_IDX          6'h2E
`define IMU_MISC_IDX          6'h30
`define IMU_DEC_IDX           6'h32
`define IMU_GLOB_IDX          6'h34
`define IMU_PART_IDX          6'h36

`define IMU_MISC_DEFAULT      16'h0001
`define IMU_MISC_DR_POL_BIT   0
`define IMU_MISC_CLK_LSB      2
`define IMU_MISC_CLK_MSB      4
`define IMU_CLK_MODE_SCALED   3'h2
`define IMU_GLOB_SAVE_BIT     3
`define IMU_GLOB_RELOAD_BIT   7

`endif

/* File: imu_pkg.sv */
// types for the two ends of the imu serial link; each type is used by one end only
package imu_pkg;
    typedef logic [15:0] imu_word_type;
    typedef imu_word_type imu_out_type [10];
    typedef enum logic [1:0] {
        IMU_DEV_LOAD = 2'b01,
        IMU_DEV_RUN  = 2'b10
    } imu_dev_st_type;
    typedef enum logic [5:0] {
        IMU_HOST_IDLE  = 6'b000001,
        IMU_HOST_LEAD  = 6'b000010,
        IMU_HOST_LOW   = 6'b000100,
        IMU_HOST_HIGH  = 6'b001000,
        IMU_HOST_TRAIL = 6'b010000,
        IMU_HOST_GAP   = 6'b100000
    } imu_host_st_type;
endpackage

/* File: imu_spi_if.sv */
// serial link between the imu device end and its master
`timescale 1ns/1ps
interface imu_spi_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic dr;
    logic miso_line;

    // released line reads as pulled high
    assign miso_line = miso_oe_n ? 1'b1 : miso_o;

    modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe_n, output dr);
    modport host (output cs_n, output sclk, output mosi, input miso_line, input dr);
endinterface

/* File: imu_dev.sv */
// device end of the imu serial link: register access, burst read, averaging, data-ready
`timescale 1ns/1ps
`include "imu_regs.svh"
module imu_dev
    import imu_pkg::*;
#(
    parameter int          P_SAMPLE_PERIOD_CYC = `IMU_SAMPLE_PERIOD_CYC,
    parameter logic [15:0] P_PART_CODE         = 16'hA5C3  // arbitrary value
) (
    input  wire logic             I_CLK,
    input  wire logic             I_RESET_N,
    input  wire logic [6:0][15:0] I_SENSOR,
    input  wire logic [15:0]      I_ERR_FLAGS,
    input  wire logic [15:0]      I_TIME_STAMP,
    output logic                  O_UPDATE,
    imu_spi_if.dev                spi
);

    logic [2:0]         pin_s1_q;
    logic [2:0]         pin_s2_q;
    logic [2:0]         pin_s3_q;
    logic [2:0]         pin_f_q;
    logic [2:0]         pin_f_d;
    imu_dev_st_type     st_q;
    imu_dev_st_type     st_d;
    logic [4:0]         load_idx_q;
    logic [4:0]         load_idx_d;
    imu_word_type       sram_q [32:63];
    imu_word_type       sram_d [32:63];
    imu_word_type       flash_q [32:63];
    logic               flash_prog_q = 1'b0;
    logic               flash_wr;
    imu_out_type        out_q;
    imu_out_type        out_d;
    imu_out_type        snap_q;
    imu_out_type        snap_d;
    imu_word_type       chk_q;
    imu_word_type       chk_d;
    imu_word_type       tx_q;
    imu_word_type       tx_d;
    imu_word_type       rx_q;
    imu_word_type       rx_d;
    logic [3:0]         bit_cnt_q;
    logic [3:0]         bit_cnt_d;
    logic [3:0]         bidx_q;
    logic [3:0]         bidx_d;
    logic               burst_q;
    logic               burst_d;
    logic signed [31:0] acc_q [7];
    logic signed [31:0] acc_d [7];
    logic [15:0]        err_acc_q;
    logic [15:0]        err_acc_d;
    logic [15:0]        nsamp_q;
    logic [15:0]        nsamp_d;
    logic [31:0]        tick_q;
    logic [31:0]        tick_d;
    logic [7:0]         dr_cnt_q;
    logic [7:0]         dr_cnt_d;
    logic               dr_q;
    logic               dr_d;
    logic               upd_q;
    logic               upd_d;
    logic               miso_q;
    logic               miso_d;
    logic               cs_high;
    logic               sclk_rise;
    logic               sclk_fall;
    logic               scaled;
    imu_word_type       dec_count;

    function automatic imu_word_type burst_sum(input imu_out_type w, input logic sc);
        imu_word_type s;
        imu_word_type v;
        s = 16'h0000;
        for (int i = 0; i < 9; i++) begin
            v = (i == 8 && sc) ? w[9] : w[i];
            s = s + {8'h00, v[15:8]} + {8'h00, v[7:0]};
        end
        return s;
    endfunction

    // a change counts once the second and third stages agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_f_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s2_q[i] : pin_f_q[i];
        end
    end

    assign cs_high   = pin_f_d[2];
    assign sclk_rise = pin_f_d[1] & ~pin_f_q[1];
    assign sclk_fall = ~pin_f_d[1] & pin_f_q[1];
    assign dec_count = sram_q[`IMU_DEC_IDX];
    assign scaled    = sram_q[`IMU_MISC_IDX][`IMU_MISC_CLK_MSB:`IMU_MISC_CLK_LSB]
                       == `IMU_CLK_MODE_SCALED;

    always_comb begin
        imu_word_type       word;
        logic [5:0]         idx;
        logic signed [31:0] avg;
        word       = {rx_q[14:0], pin_f_q[0]};
        idx        = word[14:9];
        avg        = 32'sh0;
        st_d       = st_q;
        load_idx_d = load_idx_q;
        sram_d     = sram_q;
        flash_wr   = 1'b0;
        out_d      = out_q;
        snap_d     = snap_q;
        chk_d      = chk_q;
        tx_d       = tx_q;
        rx_d       = rx_q;
        bit_cnt_d  = bit_cnt_q;
        bidx_d     = bidx_q;
        burst_d    = burst_q;
        acc_d      = acc_q;
        err_acc_d  = err_acc_q;
        nsamp_d    = nsamp_q;
        tick_d     = tick_q;
        dr_cnt_d   = (dr_cnt_q != 8'h00) ? dr_cnt_q - 8'h01 : 8'h00;
        upd_d      = 1'b0;
        miso_d     = miso_q;
        case (st_q)
            IMU_DEV_LOAD: begin
                // no flash image yet: factory defaults stand in
                sram_d[{1'b1, load_idx_q}] = flash_prog_q ? flash_q[{1'b1, load_idx_q}]
                    : (({1'b1, load_idx_q} == `IMU_MISC_IDX) ? `IMU_MISC_DEFAULT : 16'h0000);
                load_idx_d = load_idx_q + 5'h01;
                tick_d     = 32'h0;
                nsamp_d    = 16'h0000;
                err_acc_d  = 16'h0000;
                for (int i = 0; i < 7; i++) begin
                    acc_d[i] = 32'sh0;
                end
                if (load_idx_q == 5'h1F) begin
                    st_d = IMU_DEV_RUN;
                end
            end
            IMU_DEV_RUN: begin
                tick_d = tick_q + 32'h1;
                if (tick_q == 32'(P_SAMPLE_PERIOD_CYC - 1)) begin
                    tick_d    = 32'h0;
                    err_acc_d = err_acc_q | I_ERR_FLAGS;
                    nsamp_d   = nsamp_q + 16'h0001;
                    for (int i = 0; i < 7; i++) begin
                        acc_d[i] = acc_q[i] + $signed({{16{I_SENSOR[i][15]}}, I_SENSOR[i]});
                    end
                    if (nsamp_q == dec_count) begin
                        // register value n means n+1 samples per update
                        for (int i = 0; i < 7; i++) begin
                            avg          = acc_d[i] / $signed({16'h0000, dec_count} + 32'h1);
                            out_d[i + 1] = avg[15:0];
                            acc_d[i]     = 32'sh0;
                        end
                        out_d[0]  = err_acc_d;
                        out_d[8]  = out_q[8] + 16'h0001;
                        out_d[9]  = I_TIME_STAMP;
                        err_acc_d = 16'h0000;
                        nsamp_d   = 16'h0000;
                        dr_cnt_d  = `IMU_DR_PULSE_CYC;
                        upd_d     = 1'b1;
                    end
                end
            end
            default: begin
                st_d = IMU_DEV_LOAD;
            end
        endcase
        if (cs_high) begin
            bit_cnt_d = 4'h0;
            if (burst_q) begin
                burst_d = 1'b0;
                tx_d    = 16'h0000;
            end
        end else begin
            // line changes only after falling edges, never near the capture edge
            if (sclk_fall) begin
                // first fall of a word sends the msb already loaded
                if (bit_cnt_q != 4'h0) begin
                    tx_d = {tx_q[14:0], 1'b0};
                end
                miso_d = tx_d[15];
            end
            if (sclk_rise) begin
                rx_d      = word;
                bit_cnt_d = bit_cnt_q + 4'h1;
                if (bit_cnt_q == 4'hF) begin
                    tx_d = 16'h0000;
                    if (burst_q) begin
                        if (bidx_q == `IMU_BURST_WORDS) begin
                            burst_d = 1'b0;
                        end else begin
                            tx_d   = (bidx_q == 4'h9) ? chk_q
                                   : (bidx_q == 4'h8 && scaled) ? snap_q[9] : snap_q[bidx_q];
                            bidx_d = bidx_q + 4'h1;
                        end
                    end else if (word == `IMU_CMD_BURST) begin
                        burst_d = 1'b1;
                        bidx_d  = 4'h1;
                        snap_d  = out_q;
                        chk_d   = burst_sum(out_q, scaled);
                        tx_d    = out_q[0];
                    end else if (!word[15]) begin
                        case (idx)
                            `IMU_ERR_IDX:     tx_d = out_q[0];
                            `IMU_RATE_X_IDX, `IMU_RATE_Y_IDX, `IMU_RATE_Z_IDX,
                            `IMU_ACCEL_X_IDX, `IMU_ACCEL_Y_IDX, `IMU_ACCEL_Z_IDX: begin
                                tx_d = out_q[idx[3:1]];
                            end
                            `IMU_TEMP_IDX:    tx_d = out_q[7];
                            `IMU_STAMP_IDX:   tx_d = out_q[9];
                            `IMU_COUNTER_IDX: tx_d = out_q[8];
                            `IMU_PART_IDX:    tx_d = P_PART_CODE;
                            default: begin
                                tx_d = (idx[5] && idx != `IMU_GLOB_IDX) ? sram_q[idx] : 16'h0000;
                            end
                        endcase
                    end else if (st_q == IMU_DEV_RUN && idx[5]) begin
                        if (idx == `IMU_GLOB_IDX) begin
                            if (!word[8]) begin
                                flash_wr = word[`IMU_GLOB_SAVE_BIT];
                                if (word[`IMU_GLOB_RELOAD_BIT]) begin
                                    st_d       = IMU_DEV_LOAD;
                                    load_idx_d = 5'h00;
                                end
                            end
                        end else if (idx != `IMU_PART_IDX) begin
                            if (word[8]) begin
                                sram_d[idx][15:8] = word[7:0];
                            end else begin
                                sram_d[idx][7:0] = word[7:0];
                            end
                        end
                    end
                end
            end
        end
        dr_d = sram_d[`IMU_MISC_IDX][`IMU_MISC_DR_POL_BIT] ? (dr_cnt_d == 8'h00)
                                                            : (dr_cnt_d != 8'h00);
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            pin_s1_q   <= `IMU_PIN_IDLE;
            pin_s2_q   <= `IMU_PIN_IDLE;
            pin_s3_q   <= `IMU_PIN_IDLE;
            pin_f_q    <= `IMU_PIN_IDLE;
            st_q       <= IMU_DEV_LOAD;
            load_idx_q <= 5'h00;
            chk_q      <= 16'h0000;
            tx_q       <= 16'h0000;
            rx_q       <= 16'h0000;
            bit_cnt_q  <= 4'h0;
            bidx_q     <= 4'h0;
            burst_q    <= 1'b0;
            err_acc_q  <= 16'h0000;
            nsamp_q    <= 16'h0000;
            tick_q     <= 32'h0;
            dr_cnt_q   <= 8'h00;
            dr_q       <= 1'b1;
            upd_q      <= 1'b0;
            miso_q     <= 1'b0;
            // polarity default from the start: no false data-ready during load
            for (int i = 32; i < 64; i++) begin
                sram_q[i] <= (i == `IMU_MISC_IDX) ? `IMU_MISC_DEFAULT : 16'h0000;
            end
            for (int i = 0; i < 10; i++) begin
                out_q[i]  <= 16'h0000;
                snap_q[i] <= 16'h0000;
            end
            for (int i = 0; i < 7; i++) begin
                acc_q[i] <= 32'sh0;
            end
        end else begin
            pin_s1_q   <= {spi.cs_n, spi.sclk, spi.mosi};
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_f_q    <= pin_f_d;
            st_q       <= st_d;
            load_idx_q <= load_idx_d;
            sram_q     <= sram_d;
            out_q      <= out_d;
            snap_q     <= snap_d;
            chk_q      <= chk_d;
            tx_q       <= tx_d;
            rx_q       <= rx_d;
            bit_cnt_q  <= bit_cnt_d;
            bidx_q     <= bidx_d;
            burst_q    <= burst_d;
            acc_q      <= acc_d;
            err_acc_q  <= err_acc_d;
            nsamp_q    <= nsamp_d;
            tick_q     <= tick_d;
            dr_cnt_q   <= dr_cnt_d;
            dr_q       <= dr_d;
            upd_q      <= upd_d;
            miso_q     <= miso_d;
        end
    end

    // nonvolatile: survives reset, so no reset branch
    always_ff @(posedge I_CLK) begin
        if (flash_wr) begin
            flash_q      <= sram_q;
            flash_prog_q <= 1'b1;
        end
    end

    assign spi.miso_o    = miso_q;
    assign spi.miso_oe_n = pin_f_q[2];
    assign spi.dr        = dr_q;
    assign O_UPDATE      = upd_q;

endmodule

/* File: imu_host.sv */
// master end of the imu serial link: frame generator and data-ready detector
`timescale 1ns/1ps
`include "imu_regs.svh"
module imu_host
    import imu_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RESET_N,
    input  wire logic        I_REQ,
    input  wire logic [15:0] I_TX_WORD,
    input  wire logic [3:0]  I_WORDS,
    input  wire logic        I_DR_POL,
    output logic             O_BUSY,
    output logic             O_RX_VALID,
    output logic [15:0]      O_RX_WORD,
    output logic             O_DATA_READY,
    imu_spi_if.host          spi
);

    logic [1:0]      pin_s1_q;
    logic [1:0]      pin_s2_q;
    logic [1:0]      pin_s3_q;
    logic [1:0]      pin_f_q;
    logic [1:0]      pin_f_d;
    imu_host_st_type st_q;
    imu_host_st_type st_d;
    logic [6:0]      div_q;
    logic [6:0]      div_d;
    logic [3:0]      bits_q;
    logic [3:0]      bits_d;
    logic [3:0]      words_q;
    logic [3:0]      words_d;
    logic [15:0]     tx_q;
    logic [15:0]     tx_d;
    logic [15:0]     rx_q;
    logic [15:0]     rx_d;
    logic [15:0]     rxw_q;
    logic [15:0]     rxw_d;
    logic            rxv_q;
    logic            rxv_d;
    logic            rdy_q;
    logic            rdy_d;
    logic            cs_q;
    logic            cs_d;
    logic            sclk_q;
    logic            sclk_d;
    logic            mosi_q;
    logic            mosi_d;
    logic            half;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_f_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s2_q[i] : pin_f_q[i];
        end
    end

    // one half period suits the slower burst limit, so one rate serves all frames
    assign half = (div_q == 7'(`IMU_SCLK_HALF_CYC - 1));

    always_comb begin
        st_d    = st_q;
        div_d   = div_q + 7'h01;
        bits_d  = bits_q;
        words_d = words_q;
        tx_d    = tx_q;
        rx_d    = rx_q;
        rxw_d   = rxw_q;
        rxv_d   = 1'b0;
        cs_d    = cs_q;
        sclk_d  = sclk_q;
        mosi_d  = mosi_q;
        // second edge of the pulse marks fresh data
        rdy_d   = I_DR_POL ? (pin_f_d[0] & ~pin_f_q[0]) : (~pin_f_d[0] & pin_f_q[0]);
        case (st_q)
            IMU_HOST_IDLE: begin
                div_d = 7'h00;
                if (I_REQ) begin
                    tx_d    = I_TX_WORD;
                    words_d = (I_WORDS == 4'h0) ? 4'h1 : I_WORDS;
                    bits_d  = 4'h0;
                    cs_d    = 1'b0;
                    st_d    = IMU_HOST_LEAD;
                end
            end
            IMU_HOST_LEAD: begin
                if (half) begin
                    div_d  = 7'h00;
                    sclk_d = 1'b0;
                    mosi_d = tx_q[15];
                    tx_d   = {tx_q[14:0], 1'b0};
                    st_d   = IMU_HOST_LOW;
                end
            end
            IMU_HOST_LOW: begin
                if (half) begin
                    div_d  = 7'h00;
                    sclk_d = 1'b1;
                    rx_d   = {rx_q[14:0], pin_f_q[1]};
                    bits_d = bits_q + 4'h1;
                    st_d   = IMU_HOST_HIGH;
                    if (bits_q == 4'hF) begin
                        rxw_d   = {rx_q[14:0], pin_f_q[1]};
                        rxv_d   = 1'b1;
                        words_d = words_q - 4'h1;
                    end
                end
            end
            IMU_HOST_HIGH: begin
                if (half) begin
                    div_d = 7'h00;
                    if (bits_q == 4'h0 && words_q == 4'h0) begin
                        st_d = IMU_HOST_TRAIL;
                    end else begin
                        // words after the first shift zeros: harmless reads
                        sclk_d = 1'b0;
                        mosi_d = tx_q[15];
                        tx_d   = {tx_q[14:0], 1'b0};
                        st_d   = IMU_HOST_LOW;
                    end
                end
            end
            IMU_HOST_TRAIL: begin
                if (half) begin
                    div_d = 7'h00;
                    cs_d  = 1'b1;
                    st_d  = IMU_HOST_GAP;
                end
            end
            IMU_HOST_GAP: begin
                if (half) begin
                    st_d = IMU_HOST_IDLE;
                end
            end
            default: begin
                st_d = IMU_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            pin_s1_q <= `IMU_HOST_PIN_IDLE;
            pin_s2_q <= `IMU_HOST_PIN_IDLE;
            pin_s3_q <= `IMU_HOST_PIN_IDLE;
            pin_f_q  <= `IMU_HOST_PIN_IDLE;
            st_q     <= IMU_HOST_IDLE;
            div_q    <= 7'h00;
            bits_q   <= 4'h0;
            words_q  <= 4'h0;
            tx_q     <= 16'h0000;
            rx_q     <= 16'h0000;
            rxw_q    <= 16'h0000;
            rxv_q    <= 1'b0;
            rdy_q    <= 1'b0;
            cs_q     <= 1'b1;
            sclk_q   <= 1'b1;
            mosi_q   <= 1'b0;
        end else begin
            pin_s1_q <= {spi.miso_line, spi.dr};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q  <= pin_f_d;
            st_q     <= st_d;
            div_q    <= div_d;
            bits_q   <= bits_d;
            words_q  <= words_d;
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            rxw_q    <= rxw_d;
            rxv_q    <= rxv_d;
            rdy_q    <= rdy_d;
            cs_q     <= cs_d;
            sclk_q   <= sclk_d;
            mosi_q   <= mosi_d;
        end
    end

    assign spi.cs_n     = cs_q;
    assign spi.sclk     = sclk_q;
    assign spi.mosi     = mosi_q;
    assign O_BUSY       = (st_q != IMU_HOST_IDLE);
    assign O_RX_VALID   = rxv_q;
    assign O_RX_WORD    = rxw_q;
    assign O_DATA_READY = rdy_q;

endmodule

/* File: imu_spi_sva.sv */
// link checker: framing, clock phase, line release and data-ready width
`timescale 1ns/1ps
module imu_spi_sva (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_line,
    input wire logic miso_oe_n,
    input wire logic dr
);
    logic       sclk_q;
    logic [7:0] rises_q;
    logic [7:0] rises_d;
    // rising sclk edges under one chip select, cleared while deselected
    always_comb rises_d = cs_n ? 8'h00 : rises_q + {7'h00, sclk & ~sclk_q};
    always_ff @(posedge I_CLK) begin
        sclk_q  <= sclk;
        rises_q <= I_RESET_N ? rises_d : 8'h00;
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    a_sclk_idle_high: assert property (cs_n |-> sclk)
        else $error("sclk low while deselected");
    a_lead_sclk_high: assert property ($fell(cs_n) |-> sclk [*8])
        else $error("sclk fell too soon after select");
    a_sclk_low_hold: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("sclk low phase too short");
    a_mosi_stable: assert property ($rose(sclk) |-> $stable(mosi) [*8])
        else $error("mosi moved around capture edge");
    a_miso_stable: assert property ($rose(sclk) && !cs_n |-> $stable(miso_line) [*8])
        else $error("miso moved around capture edge");
    a_frame_whole: assert property ($rose(cs_n) |-> rises_q[3:0] == 4'h0 && rises_q != 8'h00)
        else $error("frame not a whole number of words");
    a_hiz_idle: assert property (cs_n [*8] |-> miso_oe_n)
        else $error("miso driven while deselected");
    a_drive_select: assert property ($fell(cs_n) |-> ##[1:8] !miso_oe_n)
        else $error("miso not driven after select");
    a_dr_width: assert property ($fell(dr) |-> ##[198:202] $rose(dr))
        else $error("data-ready pulse width wrong");
endmodule

/* File: imu_spi_register_access_tb_top.sv */
// bench: both link ends joined; register, burst, rate and flash tests
`timescale 1ns/1ps
module imu_spi_register_access_tb_top;
    import imu_pkg::*;
    localparam logic [15:0] PART = 16'h3C5A; // arbitrary value
    logic             I_CLK     = 1'b0;
    logic             I_RESET_N = 1'b0;
    logic             req       = 1'b0;
    logic [3:0]       nw        = 4'h1;
    logic [15:0]      tx        = 16'h0000;
    logic [15:0]      err       = 16'h0204;
    logic [15:0]      ts        = 16'h5A17;
    logic [6:0][15:0] sens      = {16'h0107, 16'h0F0E, 16'hFFF0, 16'h8001,
                                   16'h7FFF, 16'h1234, 16'h00AB};
    logic             busy, rxv, upd, rdy;
    logic [15:0]      rxw, sum;
    logic [15:0]      rx [11];
    int               num_errors = 0, checks = 0, cyc = 0, nrdy = 0, k;
    time              t0;
    imu_spi_if spi ();
    imu_dev #(.P_SAMPLE_PERIOD_CYC(400), .P_PART_CODE(PART)) imu_dev_i (.I_CLK, .I_RESET_N,
        .I_SENSOR(sens), .I_ERR_FLAGS(err), .I_TIME_STAMP(ts), .O_UPDATE(upd), .spi(spi));
    imu_host imu_host_i (.I_CLK, .I_RESET_N, .I_REQ(req), .I_TX_WORD(tx), .I_WORDS(nw),
        .I_DR_POL(1'b1), .O_BUSY(busy), .O_RX_VALID(rxv), .O_RX_WORD(rxw),
        .O_DATA_READY(rdy), .spi(spi));
    imu_spi_sva imu_spi_sva_i (.I_CLK, .I_RESET_N, .cs_n(spi.cs_n), .sclk(spi.sclk),
        .mosi(spi.mosi), .miso_line(spi.miso_line), .miso_oe_n(spi.miso_oe_n), .dr(spi.dr));
    initial forever #5 I_CLK = ~I_CLK;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // whole run is about 90k cycles; counted off the launching edge
    always @(negedge I_CLK) begin
        cyc++;
        if (rdy) nrdy++;
        if (cyc == 98000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst;
        I_RESET_N = 1'b0;
        repeat (4) @(negedge I_CLK);
        I_RESET_N = 1'b1;
        // config load takes 32 cycles after release
        repeat (40) @(negedge I_CLK);
    endtask
    task automatic xfer(input logic [15:0] w, input logic [3:0] n);
        k = 0;
        @(negedge I_CLK);
        tx = w;
        nw = n;
        req = 1'b1;
        @(negedge I_CLK);
        req = 1'b0;
        while (busy) begin
            @(negedge I_CLK);
            if (rxv) begin
                rx[k] = rxw;
                k++;
            end
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        xfer({1'b0, a, 8'h00}, 4'h1);
        xfer(16'h0000, 4'h1);
        chk(rx[0], exp);
    endtask
    task automatic bst;
        xfer(16'h6800, 4'hB);
        sum = {8'h00, err[15:8]} + {8'h00, err[7:0]} + {8'h00, rx[9][15:8]} + {8'h00, rx[9][7:0]};
        chk(rx[1], err);
        for (int i = 0; i < 7; i++) begin
            chk(rx[i + 2], sens[i]);
            sum += {8'h00, sens[i][15:8]} + {8'h00, sens[i][7:0]};
        end
        chk(rx[10], sum);
    endtask
    initial begin
        rst();
        rd(7'h60, 16'h0001);
        xfer(16'h6100, 4'h1);
        xfer(16'h6C00, 4'h1);
        chk(rx[0], 16'h0001);
        xfer(16'hEC00, 4'h1);
        chk(rx[0], PART);
        xfer(16'h6D00, 4'h1);
        chk(rx[0], 16'h0000);
        xfer(16'h0000, 4'h1);
        chk(rx[0], PART);
        $display("test registers done");
        xfer(16'hE403, 4'h1);
        xfer(16'hE500, 4'h1);
        rd(7'h65, 16'h0003);
        @(posedge upd);
        @(posedge upd);
        t0 = $time;
        k = nrdy;
        @(posedge upd);
        // four averaged samples of 400 cycles each
        chk(16'(($time - t0) / 10), 16'h0640);
        chk(16'(nrdy - k), 16'h0001);
        $display("test rate done");
        bst();
        $display("test burst done");
        xfer(16'hE009, 4'h1);
        xfer(16'hE100, 4'h1);
        @(posedge upd);
        @(posedge upd);
        bst();
        chk(rx[9], ts);
        $display("test scaled burst done");
        xfer(16'hE808, 4'h1);
        xfer(16'hE405, 4'h1);
        rd(7'h64, 16'h0005);
        rst();
        rd(7'h64, 16'h0003);
        rd(7'h60, 16'h0009);
        xfer(16'hE405, 4'h1);
        xfer(16'hE880, 4'h1);
        rd(7'h64, 16'h0003);
        $display("test flash done");
        end_sim();
    end
endmodule
